// ===== sdc_splitter_dac_command_handler.v
// Command handler that stores and reports the splitter DAC counts.
`include "sdc_consts.vh"
module sdc_splitter_dac_command_handler
(
	input wire sys_clk,
	input wire reset_n,
	input wire cmd_valid,
	input wire [1:0] cmd_op,
	input wire [7:0] cmd_channel,
	input wire [3:0] cmd_target,
	input wire [8:0] cmd_count,
	output reg rsp_valid,
	output reg [1:0] rsp_status,
	output reg [7:0] rsp_channel,
	output reg [3:0] rsp_target,
	output reg [8:0] rsp_count,
	output reg [23:0] att_dac,
	output reg [31:0] phase_dac,
	output reg [3:0] phase_invert,
	output reg rf_switch_enable
);
	// ----------------------------------------
	// Storage and decode
	// ----------------------------------------
	// Stored counts, one word per splitter channel.
	reg [`SDC_ATT_W-1:0] att_mem [0:`SDC_CHANNELS-1];
	reg [`SDC_PH_W-1:0] ph_mem [0:`SDC_CHANNELS-1];
	// Next values and write strobes from the reply selection.
	reg next_rsp_valid;
	reg [1:0] next_rsp_status;
	reg [`SDC_PH_W-1:0] next_rsp_count;
	reg next_rf_switch_enable;
	reg att_load;
	reg ph_load;
	wire is_att;
	wire is_phase;
	wire is_en_set;
	wire is_en_clr;
	wire [1:0] slot;
	wire is_write;
	wire is_read;
	wire hit;
	wire is_enable;
	// Loop indices, one per process, so that no variable has two drivers.
	integer i;
	integer j;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Pads a stored attenuation count to the width of a reply.
	function [`SDC_PH_W-1:0] att_reply;
		input [`SDC_ATT_W-1:0] count;
		begin
			att_reply = {{(`SDC_PH_W-`SDC_ATT_W){1'b0}}, count};
		end
	endfunction

	// Gives the lowest bit of one channel's field in a packed DAC word.
	function integer field_base;
		input integer chan;
		input integer width;
		begin
			field_base = chan * width;
		end
	endfunction

	// Gives OK for a write to a known target and the refused status otherwise.
	function [1:0] write_status;
		input known;
		begin
			if (known)
				write_status = `SDC_ST_OK;
			else
				write_status = `SDC_ST_BAD;
		end
	endfunction

	// ----------------------------------------
	// Target decode
	// ----------------------------------------
	sdc_target_decode u_decode
	(
		.target(cmd_target),
		.is_att(is_att),
		.is_phase(is_phase),
		.is_en_set(is_en_set),
		.is_en_clr(is_en_clr),
		.slot(slot)
	);

	// Op 3 is neither a read nor a write, so it draws no reply.
	// alias same write
	assign is_write = cmd_valid && ((cmd_op == `SDC_OP_WRITE) || (cmd_op == `SDC_OP_ALIAS));
	assign is_read = cmd_valid && (cmd_op == `SDC_OP_READ);
	assign hit = is_att || is_phase;
	assign is_enable = is_en_set || is_en_clr;

	// ----------------------------------------
	// Reply selection
	// ----------------------------------------
	// An unknown target, or a read of an enable target, gets the refused status.
	always @*
	begin
		next_rsp_valid = is_read || is_write;
		next_rsp_status = `SDC_ST_BAD;
		next_rsp_count = `SDC_CNT_NONE;
		next_rf_switch_enable = rf_switch_enable;
		att_load = 1'b0;
		ph_load = 1'b0;
		if (is_write)
		begin
			next_rsp_status = write_status(hit || is_enable);
			att_load = is_att;
			ph_load = is_phase;
			if (is_en_set)
			begin
				next_rf_switch_enable = 1'b1;
			end
			if (is_en_clr)
			begin
				next_rf_switch_enable = 1'b0;
			end
		end
		else if (is_read && hit)
		begin
			next_rsp_status = `SDC_ST_COUNT;
			if (is_att)
			begin
				next_rsp_count = att_reply(att_mem[slot]);
			end
			else
			begin
				next_rsp_count = ph_mem[slot];
			end
		end
	end

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			for (i = 0; i < `SDC_CHANNELS; i = i + 1)
			begin
				att_mem[i] <= `SDC_ATT_RESET;
				ph_mem[i] <= `SDC_PH_RESET;
			end
			rf_switch_enable <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_status <= `SDC_ST_OK;
			rsp_channel <= 8'h00;
			rsp_target <= 4'h0;
			rsp_count <= `SDC_CNT_NONE;
		end
		else
		begin
			if (att_load)
			begin
				att_mem[slot] <= cmd_count[`SDC_ATT_W-1:0];
			end
			if (ph_load)
			begin
				ph_mem[slot] <= cmd_count;
			end
			// Channel and target are echoed every cycle; they matter only with rsp_valid.
			rf_switch_enable <= next_rf_switch_enable;
			rsp_valid <= next_rsp_valid;
			rsp_status <= next_rsp_status;
			rsp_channel <= cmd_channel;
			rsp_target <= cmd_target;
			rsp_count <= next_rsp_count;
		end
	end

	// ----------------------------------------
	// DAC drive
	// ----------------------------------------
	// The DAC words trail the stored counts by one cycle.
	// A write therefore reaches them two cycles after it is taken.
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			att_dac <= 24'h000000;
			phase_dac <= 32'h00000000;
			phase_invert <= 4'h0;
		end
		else
		begin
			for (j = 0; j < `SDC_CHANNELS; j = j + 1)
			begin
				att_dac[field_base(j, `SDC_ATT_W) +: `SDC_ATT_W] <= att_mem[j];
				phase_dac[field_base(j, `SDC_DLY_W) +: `SDC_DLY_W] <= ph_mem[j][`SDC_DLY_W-1:0];
				phase_invert[j] <= ph_mem[j][`SDC_PH_INV_BIT];
			end
		end
	end
endmodule

// ===== sdc_consts.vh
// Constants shared by the splitter DAC command handler.
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
`define SDC_OP_READ 2'h0
`define SDC_OP_WRITE 2'h1
`define SDC_OP_ALIAS 2'h2
`define SDC_TGT_ATT1 4'h1
`define SDC_TGT_ATT2 4'h5
`define SDC_TGT_ATT3 4'h6
`define SDC_TGT_ATT4 4'h2
`define SDC_TGT_PH1 4'h3
`define SDC_TGT_PH2 4'h7
`define SDC_TGT_PH3 4'h4
`define SDC_TGT_PH4 4'h0
`define SDC_TGT_EN_SET 4'hE
`define SDC_TGT_EN_CLR 4'hF
`define SDC_ATT_W 6
`define SDC_PH_W 9
`define SDC_PH_INV_BIT 8
`define SDC_DLY_W 8
`define SDC_CHANNELS 4
`define SDC_CNT_NONE 9'h000
`define SDC_ST_OK 2'h0
`define SDC_ST_COUNT 2'h1
`define SDC_ST_BAD 2'h2
`define SDC_ATT_RESET 6'h00
`define SDC_PH_RESET 9'h000
`endif

// ===== sdc_target_decode.v
// Decoder from target code to channel slot and kind.
`include "sdc_consts.vh"
module sdc_target_decode
(
	input wire [3:0] target,
	output reg is_att,
	output reg is_phase,
	output reg is_en_set,
	output reg is_en_clr,
	output reg [1:0] slot
);
	always @*
	begin
		is_att = 1'b0;
		is_phase = 1'b0;
		is_en_set = 1'b0;
		is_en_clr = 1'b0;
		slot = 2'h0;
		case (target)
			`SDC_TGT_ATT1:
			begin
				is_att = 1'b1;
				slot = 2'h0;
			end
			`SDC_TGT_ATT2:
			begin
				is_att = 1'b1;
				slot = 2'h1;
			end
			`SDC_TGT_ATT3:
			begin
				is_att = 1'b1;
				slot = 2'h2;
			end
			`SDC_TGT_ATT4:
			begin
				is_att = 1'b1;
				slot = 2'h3;
			end
			`SDC_TGT_PH1:
			begin
				is_phase = 1'b1;
				slot = 2'h0;
			end
			`SDC_TGT_PH2:
			begin
				is_phase = 1'b1;
				slot = 2'h1;
			end
			`SDC_TGT_PH3:
			begin
				is_phase = 1'b1;
				slot = 2'h2;
			end
			`SDC_TGT_PH4:
			begin
				is_phase = 1'b1;
				slot = 2'h3;
			end
			`SDC_TGT_EN_SET:
			begin
				is_en_set = 1'b1;
			end
			`SDC_TGT_EN_CLR:
			begin
				is_en_clr = 1'b1;
			end
			default:
			begin
				slot = 2'h0;
			end
		endcase
	end
endmodule

// ===== sdc_host_model.sv
// Host model that issues one command word at a time.
module sdc_host_model
(
	input wire logic sys_clk,
	output logic cmd_valid,
	output logic [1:0] cmd_op,
	output logic [7:0] cmd_channel,
	output logic [3:0] cmd_target,
	output logic [8:0] cmd_count
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {cmd_valid, cmd_op, cmd_channel, cmd_target, cmd_count} = 24'h000000;
	task automatic send(input logic [1:0] op, input logic [3:0] tg, input logic [8:0] cn);
		@(posedge sys_clk);
		#1;
		{cmd_valid, cmd_op, cmd_channel, cmd_target} = {1'b1, op, 4'h1, tg, tg};
		cmd_count = (tg > 4'hD) ? 9'h000 : cn;
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b0;
		{cmd_channel, cmd_target, cmd_count} = ~{cmd_channel, cmd_target, cmd_count};
	endtask
endmodule

// ===== sdc_handler_properties.sv
// Port checker of the splitter DAC command handler.
module sdc_handler_properties
(
	input wire sys_clk,
	input wire reset_n,
	input wire cmd_valid,
	input wire [1:0] cmd_op,
	input wire [3:0] cmd_target,
	input wire [8:0] cmd_count,
	input wire rsp_valid,
	input wire [1:0] rsp_status,
	input wire [3:0] rsp_target,
	input wire [23:0] att_dac,
	input wire [31:0] phase_dac,
	input wire [3:0] phase_invert,
	input wire rf_switch_enable
);
	wire rq = cmd_valid && cmd_op != 2'h3;
	wire wr = rq && cmd_op != 2'h0;
	wire [3:0] t = cmd_target;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	chk_reply_taken: assert property (rq |=> rsp_valid)
		else $error("no reply");
	chk_reply_idle: assert property (!rq |=> !rsp_valid)
		else $error("stray reply");
	chk_write_ok: assert property (wr && (t < 4'h8 || t > 4'hD) |=> rsp_status == 2'h0)
		else $error("bad write status");
	chk_bad_code: assert property (rq && t > 4'h7 && t < 4'hE |=> rsp_status == 2'h2)
		else $error("bad code accepted");
	chk_read_echo: assert property (rq && !wr && t < 4'h8
		|=> rsp_status == 2'h1 && rsp_target == $past(t))
		else $error("bad read echo");
	chk_att_load: assert property (wr && t == 4'h6
		|-> ##2 att_dac[17:12] == $past(cmd_count[5:0], 2))
		else $error("att not loaded");
	chk_phase_load: assert property (wr && t == 4'h4
		|-> ##2 {phase_invert[2], phase_dac[23:16]} == $past(cmd_count, 2))
		else $error("phase not loaded");
	chk_rf_on: assert property (wr && t == 4'hE |-> ##[1:2] rf_switch_enable)
		else $error("enable not set");
endmodule
bind sdc_splitter_dac_command_handler sdc_handler_properties u_sdc_handler_properties (.*);

// ===== sdc_splitter_dac_command_handler_tb.sv
// Self-checking bench of the splitter DAC command handler.
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fails++; \
	$display("[FAIL] %s %0h %0h", n, e, a); end end
module sdc_splitter_dac_command_handler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0, reset_n = 1'b0, cmd_valid, rsp_valid, rf_switch_enable;
	logic [1:0] cmd_op, rsp_status;
	logic [7:0] cmd_channel, rsp_channel;
	logic [3:0] cmd_target, rsp_target, phase_invert;
	logic [8:0] cmd_count, rsp_count;
	logic [23:0] att_dac;
	logic [31:0] phase_dac;
	logic [3:0] tg [8] = '{4'h1, 4'h5, 4'h6, 4'h2, 4'h3, 4'h7, 4'h4, 4'h0};
	int fails = 0, compares = 0, cycles = 0;
	always #12.5 sys_clk = ~sys_clk;
	sdc_host_model u_sdc_host_model (.*);
	sdc_splitter_dac_command_handler u_sdc_splitter_dac_command_handler (.*);
	task automatic close_out;
		if (fails == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			close_out();
		end
	end
	task automatic test_counts;
		logic [8:0] v;
		logic [8:0] d;
		for (int i = 0; i < 16; i++)
		begin
			v = (i % 8 < 4) ? 9'h03F - i % 8 : 9'h0BC + 9'h05F * (i % 4);
			u_sdc_host_model.send(i > 7 ? 2'h0 : 2'h1 + i % 2, tg[i % 8], i > 7 ? 9'h000 : v);
			if (i < 8)
			begin
				`CHK("wr", {3'h4, 4'h1, tg[i]}, {rsp_valid, rsp_status, rsp_channel})
			end
			else
			begin
				`CHK("rd", {3'h5, tg[i - 8], v}, {rsp_valid, rsp_status, rsp_target, rsp_count})
				if (i < 12)
					d = {3'h0, att_dac[(i % 4) * 6 +: 6]};
				else
					d = {phase_invert[i % 4], phase_dac[(i % 4) * 8 +: 8]};
				`CHK("dac", v, d)
			end
		end
	endtask
	task automatic test_rf;
		u_sdc_host_model.send(2'h1, 4'hE, 9'h000);
		@(posedge sys_clk);
		#1;
		`CHK("on", 1'b1, rf_switch_enable)
		u_sdc_host_model.send(2'h2, 4'hF, 9'h000);
		`CHK("off", 4'h4, {rf_switch_enable, rsp_valid, rsp_status})
		u_sdc_host_model.send(2'h0, 4'h9, 9'h000);
		`CHK("bad", 3'h6, {rsp_valid, rsp_status})
		u_sdc_host_model.send(2'h0, 4'hE, 9'h000);
		`CHK("rden", 3'h6, {rsp_valid, rsp_status})
		u_sdc_host_model.send(2'h3, 4'h6, 9'h015);
		`CHK("op3", 1'b0, rsp_valid)
		u_sdc_host_model.send(2'h0, 4'h6, 9'h000);
		`CHK("kept", {3'h5, 4'h6, 9'h03D}, {rsp_valid, rsp_status, rsp_target, rsp_count})
	endtask
	initial
	begin
		repeat (3) @(posedge sys_clk);
		#1;
		reset_n = 1'b1;
		test_counts();
		test_rf();
		close_out();
	end
endmodule
